// file: fcr_detector.v
// Frequency reach and output current detector with register port
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`include "fcr_consts.vh"
module fcr_detector #(
    parameter TICK_CYCLES = `FCR_TICK_NS / `FCR_CLK_NS
) (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output wire [15:0] reg_rdata_o,
    // Drive measurements
    input wire [15:0] run_freq_i,
    input wire [15:0] out_current_i,
    input wire accel_i,
    input wire decel_i,
    // Output terminal indications
    output wire freq_reach_1_o,
    output wire freq_reach_2_o,
    output wire relay_output_terminal_o,
    output wire zero_current_o,
    output wire overcurrent_o,
    output wire cur_window_1_o,
    output wire cur_window_2_o,
    // Interrupt
    output wire irq_o
);
    // Settings
    reg [15:0] freq_reach_center_1_q;
    reg [15:0] freq_reach_halfwidth_1_q;
    reg freq_reach_mode_1_q;
    reg [15:0] freq_reach_center_2_q;
    reg [15:0] freq_reach_halfwidth_2_q;
    reg freq_reach_mode_2_q;
    reg [11:0] zero_current_level_q;
    reg [15:0] zero_current_delay_q;
    reg [11:0] overcurrent_threshold_q;
    reg [15:0] overcurrent_delay_q;
    reg [11:0] current_window_level_q [0:1];
    reg [11:0] current_window_width_q [0:1];
    reg [15:0] rated_motor_current_q;
    reg [15:0] maximum_frequency_limit_q;

    // Indications and interrupt state
    reg [`FCR_IND_W-1:0] ind_q;
    reg [`FCR_IND_W-1:0] ind_d;
    reg [`FCR_IND_W-1:0] irq_stat_q;
    reg [`FCR_IND_W-1:0] irq_stat_d;
    reg [`FCR_IND_W-1:0] irq_en_q;
    reg [15:0] rdata_q;
    reg [15:0] rdata_d;

    // Delay time base
    reg [19:0] tick_cnt_q;
    reg tick_q;

    wire ramping;
    wire [28:0] cur_scaled;
    wire zc_cond;
    wire oc_cond;
    wire zc_qual;
    wire oc_qual;
    wire [1:0] freq_hit;
    wire [1:0] win_hit;
    wire [1:0] mode_blank;
    wire clr_wr;

    // Clamp a percentage setting to its top of range
    function [11:0] clamp_pct;
        input [15:0] v;
        begin
            if (v > {4'h0, `FCR_PCT_MAX}) begin
                clamp_pct = `FCR_PCT_MAX;
            end else begin
                clamp_pct = v[11:0];
            end
        end
    endfunction

    // Clamp a 0.01 s delay setting to its top of range
    function [15:0] clamp_delay;
        input [15:0] v;
        begin
            if (v > `FCR_DELAY_MAX) begin
                clamp_delay = `FCR_DELAY_MAX;
            end else begin
                clamp_delay = v;
            end
        end
    endfunction

    // Clamp a value to an upper bound
    function [15:0] clamp_to;
        input [15:0] v;
        input [15:0] lim;
        begin
            if (v > lim) begin
                clamp_to = lim;
            end else begin
                clamp_to = v;
            end
        end
    endfunction

    // Percentage of rated current, kept in 0.1 % x current units
    function [28:0] scale_pct;
        input [12:0] pct;
        input [15:0] rated;
        begin
            scale_pct = {16'h0000, pct} * {13'h0000, rated};
        end
    endfunction

    // Frequency inside centre +/- half-width, inclusive bounds
    function freq_in_window;
        input [15:0] f;
        input [15:0] centre;
        input [15:0] half;
        reg [16:0] lo;
        reg [16:0] hi;
        begin
            lo = (centre > half) ? {1'b0, centre - half} : 17'h00000;
            hi = {1'b0, centre} + {1'b0, half};
            freq_in_window = ({1'b0, f} >= lo) && ({1'b0, f} <= hi);
        end
    endfunction

    // Scaled current inside (level +/- width) x rated current
    function cur_in_window;
        input [28:0] cur;
        input [11:0] level;
        input [11:0] width;
        input [15:0] rated;
        reg [12:0] lo_pct;
        reg [12:0] hi_pct;
        begin
            lo_pct = (level > width) ? {1'b0, level - width} : 13'h0000;
            hi_pct = {1'b0, level} + {1'b0, width};
            cur_in_window = (cur >= scale_pct(lo_pct, rated)) &&
                (cur <= scale_pct(hi_pct, rated));
        end
    endfunction

    assign ramping = accel_i | decel_i;
    // Measured current in the same scale as percentage x rated current
    assign cur_scaled = {13'h0000, out_current_i} * `FCR_PCT_SCALE;

    // Frequency channels
    assign mode_blank[0] = freq_reach_mode_1_q & ramping;
    assign mode_blank[1] = freq_reach_mode_2_q & ramping;
    assign freq_hit[0] = freq_in_window(run_freq_i, freq_reach_center_1_q,
        freq_reach_halfwidth_1_q) & ~mode_blank[0];
    assign freq_hit[1] = freq_in_window(run_freq_i, freq_reach_center_2_q,
        freq_reach_halfwidth_2_q) & ~mode_blank[1];

    // Current windows, one per group
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_win
            assign win_hit[gi] = cur_in_window(cur_scaled,
                current_window_level_q[gi], current_window_width_q[gi],
                rated_motor_current_q);
        end
    endgenerate

    // Zero and overcurrent conditions before their delays
    assign zc_cond = cur_scaled <=
        scale_pct({1'b0, zero_current_level_q}, rated_motor_current_q);
    assign oc_cond = (overcurrent_threshold_q != 12'h000) && (cur_scaled >
        scale_pct({1'b0, overcurrent_threshold_q}, rated_motor_current_q));

    fcr_delay_qual u_zc_qual (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick_q),
        .delay_i(zero_current_delay_q),
        .cond_i(zc_cond),
        .qual_o(zc_qual)
    );

    fcr_delay_qual u_oc_qual (
        .mclk_i(mclk_i),
        .sys_rst_i(sys_rst_i),
        .tick_i(tick_q),
        .delay_i(overcurrent_delay_q),
        .cond_i(oc_cond),
        .qual_o(oc_qual)
    );

    // 10 ms time base for both delays
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            tick_cnt_q <= 20'h00000;
            tick_q <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES[19:0] - 20'h00001) begin
            tick_cnt_q <= 20'h00000;
            tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 20'h00001;
            tick_q <= 1'b0;
        end
    end

    // Indication vector and interrupt status
    assign clr_wr = reg_wr_i && (reg_addr_i == `FCR_OFS_IRQ_CLR);

    always @* begin
        ind_d = {`FCR_IND_W{1'b0}};
        ind_d[`FCR_IND_REACH_1] = freq_hit[0];
        ind_d[`FCR_IND_REACH_2] = freq_hit[1];
        ind_d[`FCR_IND_ZERO] = zc_qual;
        ind_d[`FCR_IND_OVER] = oc_qual;
        ind_d[`FCR_IND_WIN_1] = win_hit[0];
        ind_d[`FCR_IND_WIN_2] = win_hit[1];
        irq_stat_d = irq_stat_q;
        if (clr_wr) begin
            irq_stat_d = irq_stat_q & ~reg_wdata_i[`FCR_IND_W-1:0];
        end
        // Rising edge sets after the clear so a simultaneous event survives
        irq_stat_d = irq_stat_d | (ind_d & ~ind_q);
    end

    // Register writes, with ranges enforced on the way in
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            freq_reach_center_1_q <= `FCR_RST_FREQ_CENTER;
            freq_reach_halfwidth_1_q <= `FCR_RST_FREQ_HALF;
            freq_reach_mode_1_q <= `FCR_RST_MODE_1;
            freq_reach_center_2_q <= `FCR_RST_FREQ_CENTER;
            freq_reach_halfwidth_2_q <= `FCR_RST_FREQ_HALF;
            freq_reach_mode_2_q <= `FCR_RST_MODE_2;
            zero_current_level_q <= `FCR_RST_ZC_LEVEL;
            zero_current_delay_q <= `FCR_RST_ZC_DELAY;
            overcurrent_threshold_q <= `FCR_RST_OC_THRESH;
            overcurrent_delay_q <= `FCR_RST_OC_DELAY;
            current_window_level_q[0] <= `FCR_RST_CW_LEVEL;
            current_window_width_q[0] <= `FCR_RST_CW_WIDTH;
            current_window_level_q[1] <= `FCR_RST_CW_LEVEL;
            current_window_width_q[1] <= `FCR_RST_CW_WIDTH;
            rated_motor_current_q <= `FCR_RST_RATED_CUR;
            maximum_frequency_limit_q <= `FCR_RST_MAX_FREQ;
            irq_en_q <= {`FCR_IND_W{1'b0}};
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `FCR_OFS_FREQ_CENTER_1: begin
                    freq_reach_center_1_q <= clamp_to(reg_wdata_i,
                        maximum_frequency_limit_q);
                end
                `FCR_OFS_FREQ_HALF_1: begin
                    freq_reach_halfwidth_1_q <= clamp_to(reg_wdata_i,
                        freq_reach_center_1_q);
                end
                `FCR_OFS_FREQ_MODE: begin
                    freq_reach_mode_1_q <= reg_wdata_i[`FCR_MODE_1_BIT];
                    freq_reach_mode_2_q <= reg_wdata_i[`FCR_MODE_2_BIT];
                end
                `FCR_OFS_FREQ_CENTER_2: begin
                    freq_reach_center_2_q <= clamp_to(reg_wdata_i,
                        maximum_frequency_limit_q);
                end
                `FCR_OFS_FREQ_HALF_2: begin
                    // Bounded by channel one's half-width, as the drive does
                    freq_reach_halfwidth_2_q <= clamp_to(reg_wdata_i,
                        freq_reach_halfwidth_1_q);
                end
                `FCR_OFS_ZC_LEVEL: begin
                    zero_current_level_q <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_ZC_DELAY: begin
                    zero_current_delay_q <= clamp_delay(reg_wdata_i);
                end
                `FCR_OFS_OC_THRESH: begin
                    overcurrent_threshold_q <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_OC_DELAY: begin
                    overcurrent_delay_q <= clamp_delay(reg_wdata_i);
                end
                `FCR_OFS_CW_LEVEL_1: begin
                    current_window_level_q[0] <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_CW_WIDTH_1: begin
                    current_window_width_q[0] <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_CW_LEVEL_2: begin
                    current_window_level_q[1] <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_CW_WIDTH_2: begin
                    current_window_width_q[1] <= clamp_pct(reg_wdata_i);
                end
                `FCR_OFS_RATED_CUR: begin
                    rated_motor_current_q <= reg_wdata_i;
                end
                `FCR_OFS_MAX_FREQ: begin
                    // Existing centres are not re-clamped; software orders writes
                    maximum_frequency_limit_q <= reg_wdata_i;
                end
                `FCR_OFS_IRQ_EN: begin
                    irq_en_q <= reg_wdata_i[`FCR_IND_W-1:0];
                end
                default: begin
                    irq_en_q <= irq_en_q;
                end
            endcase
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always @* begin
        rdata_d = 16'h0000;
        if (reg_rd_i) begin
            case (reg_addr_i)
                `FCR_OFS_FREQ_CENTER_1: rdata_d = freq_reach_center_1_q;
                `FCR_OFS_FREQ_HALF_1: rdata_d = freq_reach_halfwidth_1_q;
                `FCR_OFS_FREQ_MODE: begin
                    rdata_d[`FCR_MODE_1_BIT] = freq_reach_mode_1_q;
                    rdata_d[`FCR_MODE_2_BIT] = freq_reach_mode_2_q;
                end
                `FCR_OFS_FREQ_CENTER_2: rdata_d = freq_reach_center_2_q;
                `FCR_OFS_FREQ_HALF_2: rdata_d = freq_reach_halfwidth_2_q;
                `FCR_OFS_ZC_LEVEL: rdata_d = {4'h0, zero_current_level_q};
                `FCR_OFS_ZC_DELAY: rdata_d = zero_current_delay_q;
                `FCR_OFS_OC_THRESH: rdata_d = {4'h0, overcurrent_threshold_q};
                `FCR_OFS_OC_DELAY: rdata_d = overcurrent_delay_q;
                `FCR_OFS_CW_LEVEL_1: rdata_d = {4'h0, current_window_level_q[0]};
                `FCR_OFS_CW_WIDTH_1: rdata_d = {4'h0, current_window_width_q[0]};
                `FCR_OFS_CW_LEVEL_2: rdata_d = {4'h0, current_window_level_q[1]};
                `FCR_OFS_CW_WIDTH_2: rdata_d = {4'h0, current_window_width_q[1]};
                `FCR_OFS_RATED_CUR: rdata_d = rated_motor_current_q;
                `FCR_OFS_MAX_FREQ: rdata_d = maximum_frequency_limit_q;
                `FCR_OFS_IND: rdata_d = {10'h000, ind_q};
                `FCR_OFS_IRQ_STAT: rdata_d = {10'h000, irq_stat_q};
                `FCR_OFS_IRQ_EN: rdata_d = {10'h000, irq_en_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Indications, status and read data registers
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            ind_q <= {`FCR_IND_W{1'b0}};
            irq_stat_q <= {`FCR_IND_W{1'b0}};
            rdata_q <= 16'h0000;
        end else begin
            ind_q <= ind_d;
            irq_stat_q <= irq_stat_d;
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign freq_reach_1_o = ind_q[`FCR_IND_REACH_1];
    assign freq_reach_2_o = ind_q[`FCR_IND_REACH_2];
    assign relay_output_terminal_o = ind_q[`FCR_IND_REACH_1];
    assign zero_current_o = ind_q[`FCR_IND_ZERO];
    assign overcurrent_o = ind_q[`FCR_IND_OVER];
    assign cur_window_1_o = ind_q[`FCR_IND_WIN_1];
    assign cur_window_2_o = ind_q[`FCR_IND_WIN_2];
    assign irq_o = |(irq_stat_q & irq_en_q);
endmodule

// file: fcr_consts.vh
// Constants of the frequency and current reach detector
`ifndef FCR_CONSTS_VH
`define FCR_CONSTS_VH

// Register word offsets (byte addresses)
`define FCR_OFS_FREQ_CENTER_1 8'h00
`define FCR_OFS_FREQ_HALF_1 8'h04
`define FCR_OFS_FREQ_MODE 8'h08
`define FCR_OFS_FREQ_CENTER_2 8'h0C
`define FCR_OFS_FREQ_HALF_2 8'h10
`define FCR_OFS_ZC_LEVEL 8'h14
`define FCR_OFS_ZC_DELAY 8'h18
`define FCR_OFS_OC_THRESH 8'h1C
`define FCR_OFS_OC_DELAY 8'h20
`define FCR_OFS_CW_LEVEL_1 8'h24
`define FCR_OFS_CW_WIDTH_1 8'h28
`define FCR_OFS_CW_LEVEL_2 8'h2C
`define FCR_OFS_CW_WIDTH_2 8'h30
`define FCR_OFS_RATED_CUR 8'h34
`define FCR_OFS_MAX_FREQ 8'h38
`define FCR_OFS_IND 8'h3C
`define FCR_OFS_IRQ_STAT 8'h40
`define FCR_OFS_IRQ_CLR 8'h44
`define FCR_OFS_IRQ_EN 8'h48

// Mode register field positions
`define FCR_MODE_1_BIT 0
`define FCR_MODE_2_BIT 1

// Indication and event bit positions
`define FCR_IND_REACH_1 0
`define FCR_IND_REACH_2 1
`define FCR_IND_ZERO 2
`define FCR_IND_OVER 3
`define FCR_IND_WIN_1 4
`define FCR_IND_WIN_2 5
`define FCR_IND_W 6

// Reset values (frequency 0.01 Hz, current 0.1 %, time 0.01 s)
`define FCR_RST_FREQ_CENTER 16'h1388
`define FCR_RST_FREQ_HALF 16'h00FA
`define FCR_RST_MODE_1 1'h0
`define FCR_RST_MODE_2 1'h1
`define FCR_RST_ZC_LEVEL 12'h032
`define FCR_RST_ZC_DELAY 16'h000A
`define FCR_RST_OC_THRESH 12'h7D0
`define FCR_RST_OC_DELAY 16'h0000
`define FCR_RST_CW_LEVEL 12'h3E8
`define FCR_RST_CW_WIDTH 12'h000
`define FCR_RST_RATED_CUR 16'h03E8
`define FCR_RST_MAX_FREQ 16'h2710

// Setting limits
`define FCR_PCT_MAX 12'hBB8
`define FCR_DELAY_MAX 16'hEA60
`define FCR_PCT_SCALE 29'h00003E8

// Timing: one delay unit is 10 ms
`define FCR_CLK_NS 10
`define FCR_TICK_NS 10000000

`endif

// file: fcr_delay_qual.v
// Delay qualifier: a condition must hold for a set time before it shows
`timescale 1ns/10ps
module fcr_delay_qual (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Timing
    input wire tick_i,
    input wire [15:0] delay_i,
    // Condition in, qualified indication out
    input wire cond_i,
    output wire qual_o
);
    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    reg qual_q;
    reg qual_d;

    always @* begin
        cnt_d = cnt_q;
        qual_d = 1'b0;
        if (!cond_i) begin
            // Drop and restart at once when the condition lapses
            cnt_d = 16'h0000;
        end else begin
            if (tick_i && (cnt_q != 16'hFFFF)) begin
                cnt_d = cnt_q + 16'h0001;
            end
            // Zero delay qualifies on the first cycle of the condition
            qual_d = (cnt_q >= delay_i);
        end
    end

    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_q <= 16'h0000;
            qual_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            qual_q <= qual_d;
        end
    end

    assign qual_o = qual_q;
endmodule

// file: fcr_detector_assertions.sv
// Port-level concurrent checks for the reach detector
`timescale 1ns/10ps
`include "fcr_consts.vh"
module fcr_detector_assertions (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // Measurements
    input wire [15:0] out_current_i,
    input wire accel_i,
    input wire decel_i,
    // Indications
    input wire freq_reach_1_o,
    input wire freq_reach_2_o,
    input wire relay_output_terminal_o,
    input wire zero_current_o,
    input wire overcurrent_o,
    input wire cur_window_1_o,
    input wire cur_window_2_o,
    input wire irq_o
);
    reg [1:0] mode_q;
    reg [5:0] en_q;
    reg oc_off_q;
    wire ramp = accel_i | decel_i;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);
    // Shadows of the few settings the checks need; clamps do not touch them
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            mode_q <= 2'h2;
            en_q <= 6'h00;
            oc_off_q <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `FCR_OFS_FREQ_MODE) mode_q <= reg_wdata_i[1:0];
            if (reg_addr_i == `FCR_OFS_IRQ_EN) en_q <= reg_wdata_i[5:0];
            if (reg_addr_i == `FCR_OFS_OC_THRESH) oc_off_q <= (reg_wdata_i == 16'h0000);
        end
    end
    a_relay_copy: assert property (relay_output_terminal_o == freq_reach_1_o)
        else $error("relay terminal differs from channel one");
    a_reset_clear: assert property ($fell(sys_rst_i) |-> !(freq_reach_1_o || freq_reach_2_o
        || zero_current_o || overcurrent_o || cur_window_1_o || cur_window_2_o || irq_o))
        else $error("indication high right after reset");
    a_ramp_blank_one: assert property (ramp && mode_q[0] |=> !freq_reach_1_o)
        else $error("channel one shown during ramp");
    a_ramp_blank_two: assert property (ramp && mode_q[1] |=> !freq_reach_2_o)
        else $error("channel two shown during ramp");
    a_oc_disabled: assert property (oc_off_q [*3] |=> !overcurrent_o)
        else $error("overcurrent with zero threshold");
    a_oc_idle_drop: assert property ((out_current_i == 16'h0000) [*2] |=> !overcurrent_o)
        else $error("overcurrent held at zero current");
    a_oc_rise_cause: assert property ($rose(overcurrent_o) |-> $past(out_current_i, 2) != 16'h0000)
        else $error("overcurrent rose without current");
    a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data outside read slot");
    a_irq_masked: assert property (en_q == 6'h00 |-> !irq_o)
        else $error("interrupt with all sources masked");
    a_irq_raise: assert property ($rose(overcurrent_o) && en_q[3] |-> ##[0:1] irq_o)
        else $error("enabled overcurrent gave no interrupt");
endmodule

// file: fcr_terminal_model.sv
// Output terminal model: the load side of the indications
`timescale 1ns/10ps
module fcr_terminal_model (
    // Clock and reset
    input wire mclk_i,
    input wire sys_rst_i,
    // Terminal drives, relay in the top bit
    input wire [6:0] drive_i,
    // Terminal states seen by the load
    output wire [6:0] term_o
);
    reg [6:0] term_q;
    // Terminals settle one clock after their drive
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            term_q <= 7'h00;
        end else begin
            term_q <= drive_i;
        end
    end
    assign term_o = term_q;
endmodule

// file: fcr_detector_bench.sv
// Self-checking bench for the reach detector
`timescale 1ns/10ps
`include "fcr_consts.vh"
module fcr_detector_bench;
    localparam TICK = 10;
    reg mclk_i = 1'b0;
    reg sys_rst_i = 1'b1;
    reg [7:0] reg_addr_i = 8'h00;
    reg [15:0] reg_wdata_i = 16'h0000;
    reg reg_wr_i = 1'b0;
    reg reg_rd_i = 1'b0;
    reg [15:0] run_freq_i = 16'h0000;
    reg [15:0] out_current_i = 16'h0000;
    reg accel_i = 1'b0;
    reg decel_i = 1'b0;
    reg rd_seen_q = 1'b0;
    wire [15:0] reg_rdata_o;
    wire [6:0] ind_w;
    wire [6:0] term_w;
    wire irq_o;
    logic [15:0] exp_q[$];
    logic [31:0] rng_q = 32'h00000056;
    logic [15:0] cur;
    integer miscompares = 0;
    integer checks_done = 0;
    integer cyc = 0;
    integer i;
    logic [15:0] rv [0:19] = '{16'h1388, 16'h00FA, 16'h0002, 16'h1388, 16'h00FA, 16'h0032,
        16'h000A, 16'h07D0, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8, 16'h0000, 16'h03E8,
        16'h2710, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] ff [0:7] = '{16'h128D, 16'h128E, 16'h1482, 16'h1483, 16'h1388, 16'h1388,
        16'h1388, 16'h1388};
    logic [1:0] fm [0:7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h3, 2'h0};
    logic [5:0] fe [0:7] = '{6'h30, 6'h33, 6'h33, 6'h30, 6'h31, 6'h32, 6'h30, 6'h33};
    logic [7:0] fa = 8'h30;
    logic [7:0] fd = 8'hC0;
    logic [15:0] cb [0:3] = '{16'h031F, 16'h0320, 16'h04B0, 16'h04B1};
    always #5 mclk_i = ~mclk_i;
    fcr_detector #(.TICK_CYCLES(TICK)) uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .run_freq_i(run_freq_i),
        .out_current_i(out_current_i), .accel_i(accel_i), .decel_i(decel_i),
        .freq_reach_1_o(ind_w[0]), .freq_reach_2_o(ind_w[1]),
        .relay_output_terminal_o(ind_w[6]), .zero_current_o(ind_w[2]),
        .overcurrent_o(ind_w[3]), .cur_window_1_o(ind_w[4]), .cur_window_2_o(ind_w[5]),
        .irq_o(irq_o));
    fcr_terminal_model term (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .drive_i(ind_w),
        .term_o(term_w));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("COUNTS checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        reg_wr_i <= 1'b1;
        reg_rd_i <= 1'b0;
        reg_addr_i <= a;
        reg_wdata_i <= d;
    endtask
    // Expected read data is queued at the strobe and judged by the monitor
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge mclk_i);
        reg_rd_i <= 1'b1;
        reg_wr_i <= 1'b0;
        reg_addr_i <= a;
        exp_q.push_back(e);
    endtask
    task automatic idle(input integer n);
        repeat (n) begin
            @(posedge mclk_i);
            reg_wr_i <= 1'b0;
            reg_rd_i <= 1'b0;
        end
    endtask
    task automatic meas(input logic [15:0] f, input logic [15:0] c, input logic a,
        input logic d);
        run_freq_i <= f;
        out_current_i <= c;
        accel_i <= a;
        decel_i <= d;
    endtask
    task automatic expect_ind(input logic [5:0] e);
        idle(6);
        rd(`FCR_OFS_IND, {10'h000, e});
        check("terminals", {9'h000, term_w}, {9'h000, e[0], e});
    endtask
    // Result monitor and hang guard
    always @(posedge mclk_i) begin
        rd_seen_q <= reg_rd_i;
        cyc = cyc + 1;
        if (rd_seen_q) begin
            if (exp_q.size() == 0) begin
                miscompares = miscompares + 1;
                $display("FAIL read data with nothing expected");
            end else begin
                check("read data", reg_rdata_o, exp_q.pop_front());
            end
        end
        if (cyc > 20000) begin
            miscompares = miscompares + 1;
            $display("FAIL run exceeded its cycle limit");
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        for (i = 0; i < 20; i = i + 1) rd(8'(i * 4), rv[i]);
        idle(2);
        $display("TEST reset values done");
        for (i = 0; i < 8; i = i + 1) begin
            wr(`FCR_OFS_FREQ_MODE, {14'h0000, fm[i]});
            meas(ff[i], 16'h03E8, fa[i], fd[i]);
            expect_ind(fe[i]);
        end
        $display("TEST frequency reach done");
        wr(`FCR_OFS_RATED_CUR, 16'h07D0);
        wr(`FCR_OFS_CW_LEVEL_1, 16'h01F4);
        wr(`FCR_OFS_CW_WIDTH_1, 16'h0064);
        for (i = 0; i < 12; i = i + 1) begin
            rng_q = xs(rng_q);
            cur = (i < 4) ? cb[i] : 16'(rng_q % 601) + 16'h02BC;
            meas(16'h0000, cur, 1'b0, 1'b0);
            expect_ind({1'b0, (cur >= 16'h0320 && cur <= 16'h04B0), 4'h0});
        end
        $display("TEST current windows done");
        wr(`FCR_OFS_ZC_DELAY, 16'hFFFF);
        rd(`FCR_OFS_ZC_DELAY, 16'hEA60);
        wr(`FCR_OFS_ZC_LEVEL, 16'h1000);
        rd(`FCR_OFS_ZC_LEVEL, 16'h0BB8);
        wr(`FCR_OFS_ZC_LEVEL, 16'h0032);
        wr(`FCR_OFS_ZC_DELAY, 16'h0003);
        meas(16'h0000, 16'h0064, 1'b0, 1'b0);
        idle(10);
        expect_ind(6'h00);
        idle(20);
        expect_ind(6'h04);
        meas(16'h0000, 16'h0065, 1'b0, 1'b0);
        idle(1);
        meas(16'h0000, 16'h0064, 1'b0, 1'b0);
        idle(10);
        expect_ind(6'h00);
        $display("TEST zero current done");
        meas(16'h0000, 16'h0FA0, 1'b0, 1'b0);
        expect_ind(6'h00);
        wr(`FCR_OFS_IRQ_CLR, 16'h003F);
        rd(`FCR_OFS_IRQ_STAT, 16'h0000);
        meas(16'h0000, 16'h0FA1, 1'b0, 1'b0);
        expect_ind(6'h08);
        rd(`FCR_OFS_IRQ_STAT, 16'h0008);
        wr(`FCR_OFS_IRQ_EN, 16'h0008);
        idle(2);
        check("irq enabled", {15'h0000, irq_o}, 16'h0001);
        wr(`FCR_OFS_IRQ_EN, 16'h0000);
        idle(2);
        check("irq masked", {15'h0000, irq_o}, 16'h0000);
        wr(`FCR_OFS_IRQ_EN, 16'h0008);
        wr(`FCR_OFS_IRQ_CLR, 16'h0008);
        idle(2);
        check("irq cleared", {15'h0000, irq_o}, 16'h0000);
        rd(`FCR_OFS_IRQ_STAT, 16'h0000);
        wr(`FCR_OFS_IND, 16'hFFFF);
        expect_ind(6'h08);
        wr(`FCR_OFS_OC_DELAY, 16'h0005);
        meas(16'h0000, 16'h0000, 1'b0, 1'b0);
        idle(4);
        meas(16'h0000, 16'h0FA1, 1'b0, 1'b0);
        idle(9);
        expect_ind(6'h00);
        idle(40);
        expect_ind(6'h08);
        wr(`FCR_OFS_OC_THRESH, 16'h0000);
        meas(16'h0000, 16'hFFFF, 1'b0, 1'b0);
        expect_ind(6'h00);
        // One edge more than the read latency so the monitor judges the last read first
        idle(3);
        $display("TEST overcurrent and interrupt done");
        wrap_up();
    end
endmodule
bind fcr_detector fcr_detector_assertions chk (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i,
    .reg_wr_i, .reg_rd_i, .reg_rdata_o, .out_current_i, .accel_i, .decel_i, .freq_reach_1_o,
    .freq_reach_2_o, .relay_output_terminal_o, .zero_current_o, .overcurrent_o,
    .cur_window_1_o, .cur_window_2_o, .irq_o);
